// ### bodmon_defs.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  supply drop detector register bank.
  Assumes: included by bodmon_regs.v; Wishbone with 32-bit words, one register per word.
*/
// Operation
// RULE1: Sampling rate bit: zero gives 1 kHz, one gives 125 Hz; reset from fuse.
// RULE2: Active-state mode is read-only fuse value: disabled, continuous, sampled.
// RULE3: Active mode code 0x3 runs continuously and holds execution after wake until running.
// RULE4: Writable deep-sleep mode selects disabled, continuous or sampled; 0x3 reserved.
// RULE5: Sampling rate and active mode are not under unlock protection.
// RULE6: Threshold code is read-only fuse value; 0x2 is 2.6V, 0x7 is 4.2V.
// RULE7: Warning offset above threshold: 5%, 15%, 25%; other codes reserved.
// RULE8: Trigger select: falling below, rising above, or either crossing; others reserved.
// RULE9: Writing one to the warning interrupt enable enables it; zero disables.
// RULE10: Warning flag sets on monitor event matching the trigger select.
// RULE11: Warning flag updates only while the detector is enabled.
// RULE12: Warning status reads 1 when supply is below warning threshold, else 0.
// RULE13: Software trusts warning status only while the detector is enabled.
// RULE14: Interrupt asserted while enable and flag are set, until flag cleared.
// RULE15: Monitor follows detector mode: off when disabled, sampled in sampled mode.
// RULE16: Sleep entry switches to deep-sleep mode; wake returns to active mode.
// RULE17: Deep-sleep mode write takes effect only after the protection key unlock.
// RULE18: Writing one clears the warning flag; read-only field writes are ignored.
`ifndef BODMON_DEFS_VH
`define BODMON_DEFS_VH

`define BODMON_IDX_MODE_CTRL   4'h0
`define BODMON_IDX_THRESH      4'h1
`define BODMON_IDX_WARN_LVL    4'h8
`define BODMON_IDX_IRQ_CTRL    4'h9
`define BODMON_IDX_IRQ_FLAGS   4'ha
`define BODMON_IDX_STATUS      4'hb
`define BODMON_IDX_UNLOCK      4'hc

`define BODMON_UNLOCK_KEY      8'hd8
`define BODMON_UNLOCK_WINDOW   3'h4

`define BODMON_MODE_DIS        2'h0
`define BODMON_MODE_CONT       2'h1
`define BODMON_MODE_SAMP       2'h2
`define BODMON_MODE_CONT_HOLD  2'h3

`define BODMON_TRIG_BELOW      2'h0
`define BODMON_TRIG_ABOVE      2'h1
`define BODMON_TRIG_CROSS      2'h2

`define BODMON_BIT_SAMPRATE    4
`define BODMON_BIT_IE          0
`define BODMON_BIT_FLAG        0

`define BODMON_WARN_LVL_RST    2'h0
`define BODMON_IRQ_CTRL_RST    3'h0

// Sampling periods: 1 kHz is 1000 us, 125 Hz is 8000 us
`define BODMON_PERIOD_FAST_US  1000
`define BODMON_PERIOD_SLOW_US  8000
`define BODMON_CLK_MHZ         100
`define BODMON_WAKE_SETTLE_CYC 16'h0010

`endif

// ### bodmon_regs.v
/*
  Supply drop detector register bank: mode control, threshold code, warning
  monitor configuration, warning interrupt flag and live status, Wishbone slave.
  Assumes: fuse inputs stable around reset release; comparator outputs are
  asynchronous and pass two flip-flops here; unlock key written to an own register.
*/
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "bodmon_defs.vh"

module bodmon_regs #(
  parameter integer FAST_PERIOD_CYC = `BODMON_PERIOD_FAST_US * `BODMON_CLK_MHZ,
  parameter integer SLOW_PERIOD_CYC = `BODMON_PERIOD_SLOW_US * `BODMON_CLK_MHZ
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        fuse_samp_rate,
  input  wire [1:0]  fuse_active_mode,
  input  wire [1:0]  fuse_sleep_mode,
  input  wire [2:0]  fuse_threshold_code,
  input  wire        deep_sleep_req,
  input  wire        warn_below_raw,
  output reg         detector_enable,
  output reg         detector_sampled,
  output reg         sampling_rate_select,
  output reg  [2:0]  threshold_code,
  output reg  [1:0]  warning_offset_select,
  output reg         monitor_enable,
  output reg         monitor_sample_strobe,
  output reg         cpu_hold,
  output reg         warning_irq
);

  localparam [1:0] ST_RESET  = 2'b01;
  localparam [1:0] ST_RUN    = 2'b10;

  reg  [1:0]  state_r;
  reg  [1:0]  active_mode_r;
  reg  [1:0]  sleep_mode_r;
  reg  [2:0]  irq_ctrl_r;
  reg         flag_r;
  reg  [2:0]  unlock_cnt_r;
  reg         asleep_r;
  reg         below_s1_r;
  reg         below_s2_r;
  reg         below_prev_r;
  reg         below_held_r;
  reg  [19:0] samp_cnt_r;
  reg  [15:0] settle_cnt_r;
  reg         slp_s1_r;
  reg         slp_s2_r;

  wire [1:0]  eff_mode;
  wire        det_on;
  wire        samp_tick;
  wire        bus_req;
  wire        wr_en;
  wire [3:0]  idx;
  wire        fall_evt;
  wire        rise_evt;
  reg         trig_hit;
  reg  [7:0]  rd_byte;
  wire [19:0] period_cyc;

  assign idx       = wb_adr_i[5:2];
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en     = bus_req & wb_we_i & wb_sel_i[0];
  assign eff_mode  = asleep_r ? sleep_mode_r : active_mode_r; // RULE16
  assign det_on    = (state_r == ST_RUN) && (eff_mode != `BODMON_MODE_DIS) && (eff_mode != 2'h3 || !asleep_r);
  assign period_cyc = sampling_rate_select ? SLOW_PERIOD_CYC[19:0] : FAST_PERIOD_CYC[19:0]; // RULE1
  assign samp_tick = (samp_cnt_r == 20'h00000);
  assign fall_evt  = below_held_r & ~below_prev_r;
  assign rise_evt  = ~below_held_r & below_prev_r;

  always @* begin
    case (irq_ctrl_r[2:1]) // RULE8
      `BODMON_TRIG_BELOW: trig_hit = fall_evt;
      `BODMON_TRIG_ABOVE: trig_hit = rise_evt;
      `BODMON_TRIG_CROSS: trig_hit = fall_evt | rise_evt;
      default:            trig_hit = 1'b0;
    endcase
  end

  always @* begin
    case (idx)
      `BODMON_IDX_MODE_CTRL: rd_byte = {3'h0, sampling_rate_select, active_mode_r, sleep_mode_r};
      `BODMON_IDX_THRESH:    rd_byte = {5'h00, threshold_code};
      `BODMON_IDX_WARN_LVL:  rd_byte = {6'h00, warning_offset_select};
      `BODMON_IDX_IRQ_CTRL:  rd_byte = {5'h00, irq_ctrl_r};
      `BODMON_IDX_IRQ_FLAGS: rd_byte = {7'h00, flag_r};
      `BODMON_IDX_STATUS:    rd_byte = {7'h00, below_held_r}; // RULE12
      `BODMON_IDX_UNLOCK:    rd_byte = {5'h00, unlock_cnt_r};
      default:               rd_byte = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_r               <= ST_RESET;
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h00000000;
      active_mode_r         <= `BODMON_MODE_DIS;
      sleep_mode_r          <= `BODMON_MODE_DIS;
      sampling_rate_select  <= 1'b0;
      threshold_code        <= 3'h0;
      warning_offset_select <= `BODMON_WARN_LVL_RST;
      irq_ctrl_r            <= `BODMON_IRQ_CTRL_RST;
      flag_r                <= 1'b0;
      unlock_cnt_r          <= 3'h0;
      asleep_r              <= 1'b0;
      slp_s1_r              <= 1'b0;
      slp_s2_r              <= 1'b0;
      below_s1_r            <= 1'b0;
      below_s2_r            <= 1'b0;
      below_prev_r          <= 1'b0;
      below_held_r          <= 1'b0;
      samp_cnt_r            <= 20'h00000;
      settle_cnt_r          <= 16'h0000;
      detector_enable       <= 1'b0;
      detector_sampled      <= 1'b0;
      monitor_enable        <= 1'b0;
      monitor_sample_strobe <= 1'b0;
      cpu_hold              <= 1'b1;
      warning_irq           <= 1'b0;
    end else begin
      slp_s1_r   <= deep_sleep_req;
      slp_s2_r   <= slp_s1_r;
      below_s1_r <= warn_below_raw;
      below_s2_r <= below_s1_r;
      case (state_r)
        ST_RESET: begin
          // Fuse values captured on the first clock after reset release
          sampling_rate_select <= fuse_samp_rate;      // RULE1
          active_mode_r        <= fuse_active_mode;    // RULE2
          sleep_mode_r         <= fuse_sleep_mode;
          threshold_code       <= fuse_threshold_code; // RULE6
          state_r              <= ST_RUN;
        end
        ST_RUN: begin
          asleep_r <= slp_s2_r;
        end
        default: state_r <= ST_RESET;
      endcase

      // Wake with continuous-hold mode keeps the CPU waiting until settled
      if (state_r == ST_RUN && !slp_s2_r && asleep_r && active_mode_r == `BODMON_MODE_CONT_HOLD)
        settle_cnt_r <= `BODMON_WAKE_SETTLE_CYC; // RULE3
      else if (settle_cnt_r != 16'h0000)
        settle_cnt_r <= settle_cnt_r - 16'h0001;
      cpu_hold <= (state_r != ST_RUN) || (settle_cnt_r > 16'h0001) ||
                  (!slp_s2_r && asleep_r && active_mode_r == `BODMON_MODE_CONT_HOLD); // RULE3

      if (!det_on || samp_tick)
        samp_cnt_r <= period_cyc - 20'h00001;
      else
        samp_cnt_r <= samp_cnt_r - 20'h00001;

      detector_enable       <= det_on;
      detector_sampled      <= det_on && eff_mode == `BODMON_MODE_SAMP;
      monitor_enable        <= det_on; // RULE15
      monitor_sample_strobe <= det_on && eff_mode == `BODMON_MODE_SAMP && samp_tick; // RULE15

      // Comparator seen continuously, or only at sample ticks in sampled mode
      if (det_on && (eff_mode != `BODMON_MODE_SAMP || samp_tick)) begin // RULE15
        below_held_r <= below_s2_r;
        below_prev_r <= below_held_r;
      end else begin
        below_prev_r <= below_held_r;
      end

      if (unlock_cnt_r != 3'h0)
        unlock_cnt_r <= unlock_cnt_r - 3'h1;

      if (wr_en) begin
        case (idx)
          // Only the sleep field is writable; rate and active mode stay fuse values
          `BODMON_IDX_MODE_CTRL: // RULE5
            if (unlock_cnt_r != 3'h0 && wb_dat_i[1:0] != 2'h3) // RULE17
              sleep_mode_r <= wb_dat_i[1:0]; // RULE4
          `BODMON_IDX_WARN_LVL:
            warning_offset_select <= wb_dat_i[1:0]; // RULE7
          `BODMON_IDX_IRQ_CTRL:
            irq_ctrl_r <= wb_dat_i[2:0]; // RULE9
          `BODMON_IDX_UNLOCK:
            if (wb_dat_i[7:0] == `BODMON_UNLOCK_KEY)
              unlock_cnt_r <= `BODMON_UNLOCK_WINDOW;
          default: ; // RULE18
        endcase
      end

      // Set wins over a same-cycle clear
      if (det_on && trig_hit) // RULE11
        flag_r <= 1'b1; // RULE10
      else if (wr_en && idx == `BODMON_IDX_IRQ_FLAGS && wb_dat_i[`BODMON_BIT_FLAG])
        flag_r <= 1'b0; // RULE18

      warning_irq <= irq_ctrl_r[`BODMON_BIT_IE] & flag_r; // RULE14

      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= {24'h000000, rd_byte};
    end
  end

endmodule // bodmon_regs

// ### bmr_checker.sv
/* Port assertions for the detector register bank.
   Assumes: bound to bodmon_regs, one clock domain. */
`timescale 1ns/100ps
module bmr_checker (
  input wire        mclk,
  input wire        srst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        detector_enable,
  input wire        detector_sampled,
  input wire        sampling_rate_select,
  input wire [2:0]  threshold_code,
  input wire        monitor_enable,
  input wire        monitor_sample_strobe,
  input wire        cpu_hold,
  input wire        warning_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  fuse_fields_a: assert property (!$past(srst, 2) |-> $stable(threshold_code) && $stable(sampling_rate_select))
    else $error("fuse field moved");
  monitor_follow_a: assert property (monitor_enable == detector_enable)
    else $error("monitor off mode");
  strobe_sampled_a: assert property (monitor_sample_strobe |-> detector_sampled && detector_enable)
    else $error("strobe outside sampled mode");
  hold_bound_a: assert property (cpu_hold |-> ##[1:20] !cpu_hold)
    else $error("hold too long");
  irq_hold_a: assert property (warning_irq && !wb_cyc_i && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |=> warning_irq)
    else $error("irq dropped");
  cover property (warning_irq);
  cover property ($fell(warning_irq));
  cover property (monitor_sample_strobe);
endmodule // bmr_checker

// ### bmr_ana_model.sv
/* Supply comparator and fuse model for the detector register bank.
   Assumes: the bench sets the supply level; fuses are constants. */
`timescale 1ns/100ps
module bmr_ana_model #(
  parameter [7:0] FCTL = 8'h05,
  parameter [2:0] FLVL = 3'h7
) (
  input  wire       mclk,
  input  wire       supply_low,
  output reg        warn_below_raw,
  output wire       fuse_samp_rate,
  output wire [1:0] fuse_active_mode,
  output wire [1:0] fuse_sleep_mode,
  output wire [2:0] fuse_threshold_code
);
  assign fuse_samp_rate = FCTL[4];
  assign fuse_active_mode = FCTL[3:2];
  assign fuse_sleep_mode = FCTL[1:0];
  assign fuse_threshold_code = FLVL;
  initial warn_below_raw = 1'b0;
  always @(posedge mclk) warn_below_raw <= supply_low;
endmodule // bmr_ana_model

// ### brownout_monitor_regs_tb_top.sv
/* Self-checking bench for the detector register bank.
   Assumes: one 100 MHz clock; the analog model drives comparator and fuses. */
`timescale 1ns/100ps
module brownout_monitor_regs_tb_top;
  localparam [7:0] FCTL = 8'h05;
  localparam [2:0] FLVL = 3'h7;
  logic        mclk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic        wb_ack_o, fuse_samp_rate, deep_sleep_req = 0, warn_below_raw, supply_low = 0;
  logic [1:0]  fuse_active_mode, fuse_sleep_mode, warning_offset_select;
  logic [2:0]  fuse_threshold_code, threshold_code;
  logic        detector_enable, detector_sampled, sampling_rate_select;
  logic        monitor_enable, monitor_sample_strobe, cpu_hold, warning_irq;
  logic [7:0]  exp_q[$];
  integer      errors = 0, total_checks = 0, cycles = 0, seed = 43881, i;
  bodmon_regs #(.FAST_PERIOD_CYC(10), .SLOW_PERIOD_CYC(80)) i_dut (.*);
  bmr_ana_model #(.FCTL(FCTL), .FLVL(FLVL)) i_ana (.*);
  always #5 mclk = ~mclk;
  task chk(input [31:0] exp, input [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task final_report;
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task bus(input [5:0] a, input w, input [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input [5:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input [5:0] a, input [7:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  // Read results are compared against the oldest noted expectation
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles > 5000) begin
      errors = errors + 1;
      final_report;
    end else if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk({24'h0, exp_q.pop_front()}, wb_dat_o);
  end
  initial begin
    tick(4);
    srst <= 1'b0;
    tick(3);
    rd(6'h00, FCTL);
    for (i = 8; i < 12; i++) rd({i[3:0], 2'b00}, 8'h00);
    rd(6'h34, 8'h00);
    wr(6'h04, $random(seed));
    wr(6'h00, 32'hffffffff);
    rd(6'h04, {5'h0, FLVL});
    rd(6'h00, FCTL);
    wr(6'h30, 32'hd8);
    wr(6'h00, ($random(seed) & 32'hfffffffc) | 32'h2);
    rd(6'h00, 8'h06);
    wr(6'h30, 32'hd8);
    wr(6'h00, 32'h3);
    rd(6'h00, 8'h06);
    deep_sleep_req <= 1'b1;
    tick(40);
    chk(detector_sampled, 1'b1);
    deep_sleep_req <= 1'b0;
    tick(25);
    chk({detector_sampled, detector_enable}, 2'b01);
    for (i = 0; i < 3; i++) begin
      wr(6'h20, i);
      rd(6'h20, i[7:0]);
      chk(warning_offset_select, i[1:0]);
    end
    for (i = 0; i < 6; i++) begin
      wr(6'h24, (i % 3) * 2 + (i < 3));
      wr(6'h28, 32'h1);
      supply_low <= 1'b1;
      tick(8);
      chk(warning_irq, (i < 3) && (i % 3 != 1));
      rd(6'h28, i % 3 != 1);
      rd(6'h2c, 8'h01);
      wr(6'h28, 32'h1);
      supply_low <= 1'b0;
      tick(6);
      rd(6'h28, i % 3 != 0);
      chk(warning_irq, (i < 3) && (i % 3 != 0));
    end
    wr(6'h28, 32'h1);
    wr(6'h30, 32'hd8);
    wr(6'h00, 32'h0);
    deep_sleep_req <= 1'b1;
    tick(6);
    chk(detector_enable, 1'b0);
    supply_low <= 1'b1;
    tick(6);
    rd(6'h28, 8'h00);
    final_report;
  end
endmodule // brownout_monitor_regs_tb_top
bind bodmon_regs bmr_checker i_chk (.*);
